// *** common/ompfs_pkg.sv ***
// How it works
// - on-chip ram follows the ram enable bit; bit resets to 1
// - mode 1: 64 kbyte space, rom off, 8-bit bus after reset
// - mode 1: ports b,c address, port d data, part of port f control
// - modes 1,2: any 16-bit area makes bus 16 bits, port e data
// - mode 2: rom on, ports b,c inputs until their direction bit is 1
// - modes 2,3: usable rom limited to 56 kbytes on large-rom variants
// - modes 3,7: rom on, no external access, all ports general i/o
// - mode 4: 16 mbyte space, rom off, p1 low/a/b/c address, d/e data
// - modes 4,5: port1 low pins inputs until their direction bit is 1
// - mode 4: starts 16-bit; goes 8-bit only when all areas 8-bit
// - modes 5,6: starts 8-bit; goes 16-bit with port e when any area 16-bit
// - mode 6: rom on, p1 low/a/b/c inputs until direction bit is 1
// - 64 kbyte space in modes 1-3, 16 mbyte in modes 4-7
// - modes 4-6 split the space into eight areas with own widths
// - port functions per mode: p1 low, pa low, pf upper pins
// - mode is the 3-bit pin value; only 1 to 7 are valid
// - expanded modes: any 16-bit area gives 16-bit bus, else 8-bit
package ompfs_pkg;
  localparam int          NUM_AREAS      = 8;
  localparam int          MODE_W         = 3;
  localparam int          PORT_W         = 8;
  localparam int          P1LOW_W        = 4;
  // register byte addresses
  localparam logic [11:0] MODE_REG_ADDR  = 12'h000;
  localparam logic [11:0] SYS_REG_ADDR   = 12'h004;
  localparam logic [11:0] AREA_REG_ADDR  = 12'h008;
  localparam logic [11:0] DDR_REG_ADDR   = 12'h00C;
  localparam logic [11:0] STAT_REG_ADDR  = 12'h010;
  // mode register layout
  localparam logic [7:0]  MODE_REG_FIXED = 8'h80;
  // system control register
  localparam logic [7:0]  SYS_RESET      = 8'h01;
  localparam logic [7:0]  SYS_WMASK      = 8'hB9;
  localparam int          RAM_EN_BIT     = 0;
  // area width register: bit per area, 1 = 16-bit access
  localparam logic [7:0]  AREA_ALL8      = 8'h00;
  localparam logic [7:0]  AREA_ALL16     = 8'hFF;
  // direction register fields: [3:0] p1 low, [7:4] unused, [15:8] port b, [23:16] port c, [27:24] port a low
  localparam int          DDR_P1_LSB     = 0;
  localparam int          DDR_PB_LSB     = 8;
  localparam int          DDR_PC_LSB     = 16;
  localparam int          DDR_PA_LSB     = 24;
  // address space sizes in kbytes
  localparam int          SPACE_NORMAL_KB = 64;
  localparam int          SPACE_ADV_KB    = 16384;
  localparam int          ROM_NORMAL_KB   = 56;
  // status register bit positions
  localparam int          ST_ROM    = 0;
  localparam int          ST_ADV    = 1;
  localparam int          ST_BUS16  = 2;
  localparam int          ST_EXT    = 3;
  localparam int          ST_ROMLIM = 4;
  localparam int          ST_VALID  = 5;
  localparam int          ST_PE_D   = 6;
  localparam int          ST_PFU_C  = 7;
  localparam int          ST_MODE_LSB = 8;
  typedef enum logic [2:0] {
    OMPFS_M0, OMPFS_M1, OMPFS_M2, OMPFS_M3, OMPFS_M4, OMPFS_M5, OMPFS_M6, OMPFS_M7
  } ompfs_mode_t;
endpackage : ompfs_pkg

// *** design/ompfs_mode_decode.sv ***
// decodes the captured mode into the static system attributes
module ompfs_mode_decode
  import ompfs_pkg::*;
(
  input  wire logic [MODE_W-1:0] mode,
  output logic                   mode_valid,
  output logic                   rom_en,
  output logic                   adv_mode,
  output logic                   expanded,
  output logic                   rom_limit,
  output logic                   start_16,
  output logic                   area_split
);
  // one process covers the whole mode table
  always_comb begin
    mode_valid = (mode != MODE_W'(OMPFS_M0));
    adv_mode   = mode[2];
    rom_en     = mode_valid && (mode[1] == 1'b1);
    expanded   = mode_valid && !(mode[1] && mode[0]);
    rom_limit  = (mode == MODE_W'(OMPFS_M2)) || (mode == MODE_W'(OMPFS_M3));
    start_16   = (mode == MODE_W'(OMPFS_M4));
    area_split = adv_mode && expanded;
  end
endmodule : ompfs_mode_decode

// *** design/ompfs_pin_select.sv ***
// per-pin address drive: a pin drives only in its address role, and on a gated port only with direction bit set
module ompfs_pin_select
  import ompfs_pkg::*;
#(
  parameter int WIDTH = PORT_W
) (
  input  wire logic [WIDTH-1:0] ddr,
  input  wire logic             addr_role,
  input  wire logic             ddr_gated,
  output logic      [WIDTH-1:0] addr_oe
);
  // a gated port comes up as inputs; ungated address ports drive at once
  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    assign addr_oe[i] = addr_role && (!ddr_gated || ddr[i]);
  end
endmodule : ompfs_pin_select

// *** design/ompfs_top.sv ***
// operating mode capture, bus width control and pin function select with apb registers
//
// Our own choices: the register offsets and register access over APB.
module ompfs_top
  import ompfs_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [MODE_W-1:0]   operating_mode_pins,
  output logic                     onchip_ram_enable,
  output logic                     onchip_rom_enable,
  output logic                     rom_limit_56k,
  output logic                     advanced_mode,
  output logic                     external_access_en,
  output logic                     bus_16bit,
  output logic                     mode_invalid,
  output logic      [P1LOW_W-1:0]  port1_low_addr_oe,
  output logic      [P1LOW_W-1:0]  porta_low_addr_oe,
  output logic      [PORT_W-1:0]   portb_addr_oe,
  output logic      [PORT_W-1:0]   portc_addr_oe,
  output logic                     portd_data_en,
  output logic                     porte_data_en,
  output logic                     portf_upper_control_en,
  output logic                     portf_other_control_en,
  output logic                     port1_low_timer_en
);
  logic                  captured_r, captured_nxt;
  logic [MODE_W-1:0]     mode_r, mode_nxt;
  logic [7:0]            sys_r, sys_nxt;
  logic [NUM_AREAS-1:0]  area16_r, area16_nxt;
  logic [31:0]           ddr_r, ddr_nxt;
  logic [31:0]           prdata_r, prdata_nxt;
  logic                  mode_valid, rom_en, adv, ext, rom_lim, start16, split;
  logic                  wr_en, rd_en, addr_hit;
  logic [31:0]           status;
  logic                  p1_role, pa_role, pbc_role, pbc_gated;

  ompfs_mode_decode u_dec (
    .mode       (mode_r),
    .mode_valid (mode_valid),
    .rom_en     (rom_en),
    .adv_mode   (adv),
    .expanded   (ext),
    .rom_limit  (rom_lim),
    .start_16   (start16),
    .area_split (split)
  );

  // apb access strobes; zero wait states so the access phase ends in its first cycle
  assign wr_en    = psel && penable && pwrite;
  assign rd_en    = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign addr_hit = (paddr == MODE_REG_ADDR) || (paddr == SYS_REG_ADDR) || (paddr == AREA_REG_ADDR) ||
                    (paddr == DDR_REG_ADDR) || (paddr == STAT_REG_ADDR);
  assign pslverr  = psel && penable && !addr_hit;

  // mode is caught once, on the first edge after reset release, and never again
  always_comb begin
    captured_nxt = 1'b1;
    mode_nxt     = captured_r ? mode_r : operating_mode_pins;
  end

  // software state: system control, area widths, direction bits
  always_comb begin
    sys_nxt    = sys_r;
    area16_nxt = area16_r;
    ddr_nxt    = ddr_r;
    // area widths start from the mode's reset width until the mode is known
    if (!captured_r) begin
      area16_nxt = (operating_mode_pins == MODE_W'(OMPFS_M4)) ? AREA_ALL16 : AREA_ALL8;
    end else if (wr_en) begin
      unique case (paddr)
        SYS_REG_ADDR:  sys_nxt    = (pwdata[7:0] & SYS_WMASK);
        // every expanded mode takes area widths, so modes 1 and 2 can widen too
        AREA_REG_ADDR: area16_nxt = ext ? pwdata[NUM_AREAS-1:0] : area16_r;
        DDR_REG_ADDR:  ddr_nxt    = pwdata;
        default: ;
      endcase
    end
  end

  // read data is latched in the setup cycle and held through the access phase
  always_comb begin
    prdata_nxt = prdata_r;
    if (rd_en) begin
      unique case (paddr)
        MODE_REG_ADDR: prdata_nxt = {24'h000000, MODE_REG_FIXED | {5'h00, mode_r}};
        SYS_REG_ADDR:  prdata_nxt = {24'h000000, sys_r};
        AREA_REG_ADDR: prdata_nxt = {24'h000000, area16_r};
        DDR_REG_ADDR:  prdata_nxt = ddr_r;
        STAT_REG_ADDR: prdata_nxt = status;
        default:       prdata_nxt = 32'h00000000;
      endcase
    end
  end

  // all control state registered here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      captured_r <= 1'b0;
      mode_r     <= MODE_W'(OMPFS_M0);
      sys_r      <= SYS_RESET;
      area16_r   <= AREA_ALL8;
      ddr_r      <= 32'h00000000;
      prdata_r   <= 32'h00000000;
    end else begin
      captured_r <= captured_nxt;
      mode_r     <= mode_nxt;
      sys_r      <= sys_nxt;
      area16_r   <= area16_nxt;
      ddr_r      <= ddr_nxt;
      prdata_r   <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;

  // bus width: any 16-bit area makes a 16-bit bus in every expanded mode
  always_comb begin
    bus_16bit = ext && captured_r && (|area16_r);
  end

  // ram enable drives the ram directly; the transfer engine hazard is software's to avoid
  assign onchip_ram_enable  = sys_r[RAM_EN_BIT];
  assign onchip_rom_enable  = captured_r && rom_en;
  assign rom_limit_56k      = captured_r && rom_lim;
  assign advanced_mode      = captured_r && adv;
  assign external_access_en = captured_r && ext;
  assign mode_invalid       = captured_r && !mode_valid;

  // port roles per mode; single-chip modes leave everything to general i/o
  always_comb begin
    p1_role   = captured_r && ext && adv;
    pa_role   = p1_role;
    pbc_role  = captured_r && ext;
    pbc_gated = (mode_r == MODE_W'(OMPFS_M2)) || (mode_r == MODE_W'(OMPFS_M6));
    portd_data_en          = captured_r && ext;
    porte_data_en          = bus_16bit;
    portf_upper_control_en = captured_r && ext;
    portf_other_control_en = captured_r && ext;
    port1_low_timer_en     = !p1_role;
  end

  // port 1 low pins always wait for their direction bits in the address modes
  ompfs_pin_select #(.WIDTH(P1LOW_W)) u_p1 (
    .ddr       (ddr_r[DDR_P1_LSB +: P1LOW_W]),
    .addr_role (p1_role),
    .ddr_gated (1'b1),
    .addr_oe   (port1_low_addr_oe)
  );

  // port a low is gated only in mode 6
  ompfs_pin_select #(.WIDTH(P1LOW_W)) u_pa (
    .ddr       (ddr_r[DDR_PA_LSB +: P1LOW_W]),
    .addr_role (pa_role),
    .ddr_gated (mode_r == MODE_W'(OMPFS_M6)),
    .addr_oe   (porta_low_addr_oe)
  );

  ompfs_pin_select #(.WIDTH(PORT_W)) u_pb (
    .ddr       (ddr_r[DDR_PB_LSB +: PORT_W]),
    .addr_role (pbc_role),
    .ddr_gated (pbc_gated),
    .addr_oe   (portb_addr_oe)
  );

  ompfs_pin_select #(.WIDTH(PORT_W)) u_pc (
    .ddr       (ddr_r[DDR_PC_LSB +: PORT_W]),
    .addr_role (pbc_role),
    .ddr_gated (pbc_gated),
    .addr_oe   (portc_addr_oe)
  );

  // status word shows the decoded mode attributes
  always_comb begin
    status                               = 32'h00000000;
    status[ST_ROM]                       = onchip_rom_enable;
    status[ST_ADV]                       = advanced_mode;
    status[ST_BUS16]                     = bus_16bit;
    status[ST_EXT]                       = external_access_en;
    status[ST_ROMLIM]                    = rom_limit_56k;
    status[ST_VALID]                     = captured_r && mode_valid;
    status[ST_PE_D]                      = porte_data_en;
    status[ST_PFU_C]                     = portf_upper_control_en;
    status[ST_MODE_LSB +: MODE_W]        = mode_r;
  end
endmodule : ompfs_top

// *** verification/ompfs_chk_sva.sv ***
// watches the mode decode outputs against the register writes that steer them
module ompfs_chk
  import ompfs_pkg::*;
(
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [11:0]         paddr,
  input wire logic [31:0]         pwdata,
  input wire logic                pslverr,
  input wire logic                onchip_ram_enable,
  input wire logic                onchip_rom_enable,
  input wire logic                rom_limit_56k,
  input wire logic                advanced_mode,
  input wire logic                external_access_en,
  input wire logic                bus_16bit,
  input wire logic [P1LOW_W-1:0]  port1_low_addr_oe,
  input wire logic [P1LOW_W-1:0]  porta_low_addr_oe,
  input wire logic [PORT_W-1:0]   portb_addr_oe,
  input wire logic                portd_data_en,
  input wire logic                porte_data_en
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // completed write access, pready is always high
  wire logic wr_acc = psel && penable && pwrite;
  ram_bit_follow_a: assert property (wr_acc && paddr == SYS_REG_ADDR |=> onchip_ram_enable == $past(pwdata[RAM_EN_BIT]))
    else $error("ram enable did not follow write");
  area_width_a: assert property (wr_acc && paddr == AREA_REG_ADDR && advanced_mode && external_access_en
    |=> bus_16bit == (|$past(pwdata[7:0])))
    else $error("bus width not set by area bits");
  porte_pair_a: assert property (porte_data_en == bus_16bit)
    else $error("port e data differs from bus width");
  single_chip_a: assert property (!external_access_en |-> !portd_data_en && !bus_16bit && portb_addr_oe == 8'h00)
    else $error("external bus active without external access");
  rom_limit_a: assert property (rom_limit_56k |-> onchip_rom_enable && !advanced_mode)
    else $error("rom limit outside normal rom modes");
  p1_addr_a: assert property (|port1_low_addr_oe |-> advanced_mode && external_access_en)
    else $error("port1 address outside advanced expanded");
  normal_space_a: assert property (!advanced_mode |-> port1_low_addr_oe == 4'h0 && porta_low_addr_oe == 4'h0)
    else $error("upper address pins in normal mode");
  mode_static_a: assert property (presetn && $past(presetn)
    |=> $stable({advanced_mode, onchip_rom_enable, external_access_en}))
    else $error("mode outputs changed in operation");
  unmapped_err_a: assert property (psel && penable && paddr > STAT_REG_ADDR |-> pslverr)
    else $error("unmapped access without error");
  cover property (wr_acc && paddr == AREA_REG_ADDR ##1 bus_16bit);
  cover property (pslverr);
  cover property (|port1_low_addr_oe);
endmodule : ompfs_chk

bind ompfs_top ompfs_chk ompfs_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .onchip_ram_enable(onchip_ram_enable),
  .onchip_rom_enable(onchip_rom_enable), .rom_limit_56k(rom_limit_56k), .advanced_mode(advanced_mode),
  .external_access_en(external_access_en), .bus_16bit(bus_16bit), .port1_low_addr_oe(port1_low_addr_oe),
  .porta_low_addr_oe(porta_low_addr_oe), .portb_addr_oe(portb_addr_oe), .portd_data_en(portd_data_en),
  .porte_data_en(porte_data_en));

// *** verification/ompfs_ext_mem.sv ***
// external memory view: data width it sees on the expanded bus, zero with no bus
module ompfs_ext_mem
  import ompfs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic external_access_en,
  input wire logic portd_data_en,
  input wire logic porte_data_en,
  output logic     [4:0] width_seen
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] width_nxt;
  // no lanes unless port d carries data; port e adds the upper byte
  always_comb begin
    width_nxt = !(external_access_en && portd_data_en) ? 5'h00 : (porte_data_en ? 5'h10 : 5'h08);
  end
  // registered, so the bench reads it one edge after a width change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) width_seen <= 5'h00;
    else width_seen <= width_nxt;
  end
endmodule : ompfs_ext_mem

// *** verification/ompfs_top_tb.sv ***
`define CHK(a, b, m) begin tests_run++; if ((a) !== (b)) begin n_errors++; $display("mismatch at %0t: %s", $time, m); end end
module ompfs_top_tb;
  import ompfs_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [2:0] operating_mode_pins = 3'h0;
  logic pready, pslverr, er, ram, rom, lim, adv, ext, b16, inv, pd, pe, pfu, pfo, tim;
  logic [3:0] p1, pa;
  logic [7:0] pb, pc;
  logic [4:0] width;
  int n_errors = 0, tests_run = 0;
  // per mode: rom lim adv ext inv b16 pd pe pfu pfo tim ram &pa &pb &pc |p1
  logic [15:0] exp_tab [8] = '{16'h0830, 16'h12F6, 16'hD2F0, 16'hC030, 16'h37DE, 16'h32DE, 16'hB2D0, 16'hA030};
  wire logic [15:0] obs = {rom, lim, adv, ext, inv, b16, pd, pe, pfu, pfo, tim, ram, &pa, &pb, &pc, |p1};
  ompfs_top ompfs_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .operating_mode_pins(operating_mode_pins), .onchip_ram_enable(ram), .onchip_rom_enable(rom),
    .rom_limit_56k(lim), .advanced_mode(adv), .external_access_en(ext), .bus_16bit(b16), .mode_invalid(inv),
    .port1_low_addr_oe(p1), .porta_low_addr_oe(pa), .portb_addr_oe(pb), .portc_addr_oe(pc), .portd_data_en(pd),
    .porte_data_en(pe), .portf_upper_control_en(pfu), .portf_other_control_en(pfo), .port1_low_timer_en(tim));
  ompfs_ext_mem ompfs_ext_mem_i (.pclk(pclk), .presetn(presetn), .external_access_en(ext), .portd_data_en(pd),
    .porte_data_en(pe), .width_seen(width));
  always #12.5 pclk = ~pclk;
  // one apb transfer, held until pready; two idle edges let registered views settle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : apb
  // reset with the mode pins set; capture happens on the first edge after release
  task automatic boot(input logic [2:0] m);
    presetn <= 1'b0; operating_mode_pins <= m;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask : boot
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  initial begin
    #200us;
    n_errors++;
    finish_test();
  end
  initial begin
    for (int m = 0; m < 8; m++) begin
      boot(3'(m));
      `CHK(obs, exp_tab[m], "pin functions after reset")
      apb(1'b0, MODE_REG_ADDR, 32'h0);
      `CHK(rd[7:0], MODE_REG_FIXED | 8'(m), "mode readback")
      $display("mode %0d test done", m);
    end
    boot(3'd5);
    apb(1'b1, AREA_REG_ADDR, 32'h1);
    `CHK({b16, pe, width}, {2'b11, 5'h10}, "one wide area")
    apb(1'b1, AREA_REG_ADDR, 32'h0);
    `CHK({b16, width}, {1'b0, 5'h08}, "all narrow areas")
    apb(1'b1, DDR_REG_ADDR, 32'h5);
    `CHK(p1, 4'h5, "port1 low per pin")
    apb(1'b1, SYS_REG_ADDR, 32'h0); // no transfer engine runs while ram is off
    `CHK(ram, 1'b0, "ram disabled")
    apb(1'b1, SYS_REG_ADDR, 32'hFF);
    apb(1'b0, SYS_REG_ADDR, 32'h0);
    `CHK({ram, rd[7:0]}, {1'b1, 8'hB9}, "system register mask")
    apb(1'b0, 12'h020, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0}, "unmapped read")
    operating_mode_pins <= 3'd3;
    repeat (3) @(posedge pclk);
    `CHK({adv, ext, rom}, 3'b110, "mode held after pin change")
    apb(1'b0, STAT_REG_ADDR, 32'h0);
    `CHK(rd, 32'h000005AA, "status word")
    $display("mode 5 test done");
    boot(3'd4);
    apb(1'b1, AREA_REG_ADDR, 32'hFE);
    `CHK(b16, 1'b1, "one area still wide")
    apb(1'b1, AREA_REG_ADDR, 32'h0);
    `CHK(b16, 1'b0, "all areas narrow")
    boot(3'd1);
    apb(1'b1, AREA_REG_ADDR, 32'h1);
    `CHK({b16, pe}, 2'b11, "normal expanded widens")
    boot(3'd2);
    apb(1'b1, DDR_REG_ADDR, 32'h0000FF00);
    `CHK({pb, pc}, {8'hFF, 8'h00}, "port b by direction")
    boot(3'd6);
    apb(1'b1, DDR_REG_ADDR, 32'h0F00FF0F);
    `CHK({pa, pb, pc, p1}, {4'hF, 8'hFF, 8'h00, 4'hF}, "mode 6 direction gating")
    boot(3'd3);
    apb(1'b1, AREA_REG_ADDR, 32'h1);
    `CHK({b16, width}, {1'b0, 5'h00}, "single chip stays off bus")
    $display("awkward tests done");
    finish_test();
  end
endmodule : ompfs_top_tb
